// ---- tcu_compare.sv ----
/*
  tcu_compare: compare stage of a capture/compare unit with its apb
  register file, a built-in 16-bit timer, pin drive, adc start and irq.
  assumes a single pclk domain; the pin buffer lives outside.
*/
`timescale 1ns/1ps
module tcu_compare import tcu_pkg::*; (
  input  wire logic        pclk,            // 50 mhz clock
  input  wire logic        presetn,         // async reset, low active
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb access phase
  input  wire logic        pwrite,          // apb direction
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error, unmapped address
  output logic             compare_pin_o,   // compare_pin drive level
  output logic             compare_pin_oe,  // high while unit drives pin
  output logic             special_event,   // special event trigger level
  output logic             adc_go,          // adc go/done set pulse
  output logic             irq              // level interrupt
);

  tcu_apb_req_t req;                        // bundled bus request
  tcu_ctrl_t    ctrl_reg;                   // compare_control
  logic [15:0]  compare_reg;                // compare_value
  logic [7:0]   prescale_reg;               // timer divider
  logic [TCU_ST_WIDTH-1:0] status_reg;      // sticky flags
  logic [TCU_ST_WIDTH-1:0] status_next;
  logic [TCU_ST_WIDTH-1:0] mask_reg;        // interrupt mask
  logic         latch_reg;                  // compare output latch
  logic         latch_next;
  logic         match_reg;                  // count equals compare now
  logic         match_next;
  logic         match_reg_d;                // match one cycle earlier
  tcu_ctrl_t    ctrl_next;                  // control value after this edge
  logic         sev_reg;                    // special event trigger level
  logic         adc_go_reg;
  logic         oe_reg;
  logic         irq_reg;
  logic [31:0]  prdata_reg;
  logic         pready_reg;
  logic         pslverr_reg;

  // timer wiring
  logic [15:0]  count;
  logic [15:0]  count_next;
  logic         tick;
  logic         overflow;

  // bus decode wires
  logic         setup_ph;                   // first cycle of a transfer
  logic         access_done;                // transfer completes this edge
  logic         wr_done;
  logic         rd_done;
  logic         mapped;
  logic [31:0]  rd_mux;
  logic [15:0]  compare_next;
  logic         ctrl_wr;
  logic         match_rise;
  logic         pin_mode;
  logic         sev_mode;

  // returns true for a write to the given offset
  function automatic logic wr_hit(input tcu_apb_req_t r, input logic [7:0] ofs);
    return r.sel && r.enable && r.write && (r.addr == ofs);
  endfunction : wr_hit

  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  // bus phase decode; ready is high in every access phase (zero wait)
  assign setup_ph    = psel && !penable;
  assign access_done = psel && penable && pready_reg;
  assign wr_done     = access_done && pwrite;
  assign rd_done     = access_done && !pwrite;
  assign mapped      = (paddr == TCU_OFS_CTRL)    || (paddr == TCU_OFS_COMPARE)  ||
                       (paddr == TCU_OFS_COUNT)   || (paddr == TCU_OFS_STATUS)   ||
                       (paddr == TCU_OFS_MASK)    || (paddr == TCU_OFS_PRESCALE) ||
                       (paddr == TCU_OFS_PINSTATE);
  assign ctrl_wr     = pready_reg && wr_hit(req, TCU_OFS_CTRL);
  // trigger and adc start look at the control value after this edge, so a
  // mode change reaches the trigger level and the adc start in one cycle
  assign ctrl_next   = ctrl_wr ? tcu_ctrl_t'(pwdata[5:0]) : ctrl_reg;

  // read mux, unused bits read zero
  assign rd_mux = (paddr == TCU_OFS_CTRL)     ? {26'h0, ctrl_reg} :
                  (paddr == TCU_OFS_COMPARE)  ? {16'h0, compare_reg} :
                  (paddr == TCU_OFS_COUNT)    ? {16'h0, count} :
                  (paddr == TCU_OFS_STATUS)   ? {29'h0, status_reg} :
                  (paddr == TCU_OFS_MASK)     ? {29'h0, mask_reg} :
                  (paddr == TCU_OFS_PRESCALE) ? {24'h0, prescale_reg} :
                  (paddr == TCU_OFS_PINSTATE) ? {29'h0, sev_reg, oe_reg, latch_reg} :
                  32'h0;

  // mode decode; 1010 and 1011 leave the pin to the port logic
  assign pin_mode = (ctrl_reg.mode == TCU_MODE_TOGGLE) || (ctrl_reg.mode == TCU_MODE_SET) ||
                    (ctrl_reg.mode == TCU_MODE_CLEAR);
  assign sev_mode = (ctrl_reg.mode == TCU_MODE_SPEVT);

  assign compare_next = (pready_reg && wr_hit(req, TCU_OFS_COMPARE)) ? pwdata[15:0]
                                                                      : compare_reg;

  tcu_timer #(
    .CW (16),
    .PW (8)
  ) u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (ctrl_reg.run),
    .prescale   (prescale_reg),
    .load       (pready_reg && wr_hit(req, TCU_OFS_COUNT)),
    .load_value (pwdata[15:0]),
    // the live match is sampled at the tick, so moving the compare value
    // away before then cancels the reset
    .clear_req  (sev_mode && match_reg),
    .count      (count),
    .count_next (count_next),
    .tick       (tick),
    .overflow   (overflow)
  );

  // equality is registered from next values so match_reg is high exactly
  // in the cycles where the count equals the compare value
  assign match_next = (count_next == compare_next);
  assign match_rise = match_reg && !match_reg_d;

  // output latch action on a new match
  always_comb begin
    latch_next = latch_reg;
    if (match_rise) begin
      unique case (ctrl_reg.mode)
        TCU_MODE_TOGGLE: latch_next = !latch_reg;
        TCU_MODE_SET:    latch_next = 1'b1;
        TCU_MODE_CLEAR:  latch_next = 1'b0;
        default:         latch_next = latch_reg;
      endcase
    end
    if (ctrl_wr && (pwdata[5:0] == 6'h00)) begin
      latch_next = 1'b0;
    end
  end

  // sticky flags: a read clears, but an event in the same cycle wins
  always_comb begin
    // only the bits handed out at setup are cleared, so an event that lands
    // between the setup edge and the access edge is kept for the next read
    status_next = (rd_done && (paddr == TCU_OFS_STATUS)) ?
                  (status_reg & ~prdata_reg[TCU_ST_WIDTH-1:0]) : status_reg;
    if (match_rise) begin
      status_next[TCU_ST_MATCH_BIT] = 1'b1;
    end
    if (overflow) begin
      status_next[TCU_ST_OVF_BIT] = 1'b1;
    end
    if (match_rise && sev_mode) begin
      status_next[TCU_ST_SEV_BIT] = 1'b1;
    end
  end

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= '0;
      compare_reg  <= TCU_RST_COMPARE;
      prescale_reg <= TCU_RST_PRESCALE;
      mask_reg     <= '0;
    end else begin
      compare_reg <= compare_next;
      ctrl_reg    <= ctrl_next;
      if (pready_reg && wr_hit(req, TCU_OFS_MASK)) begin
        mask_reg <= pwdata[TCU_ST_WIDTH-1:0];
      end
      if (pready_reg && wr_hit(req, TCU_OFS_PRESCALE)) begin
        prescale_reg <= pwdata[7:0];
      end
    end
  end

  // compare state and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_reg   <= 1'b0;
      match_reg_d <= 1'b0;
      latch_reg   <= 1'b0;
      sev_reg     <= 1'b0;
      adc_go_reg  <= 1'b0;
      oe_reg      <= 1'b0;
      status_reg  <= '0;
      irq_reg     <= 1'b0;
    end else begin
      match_reg   <= match_next;
      match_reg_d <= match_reg;
      latch_reg   <= latch_next;
      // trigger level tracks the match with no added delay
      sev_reg     <= match_next && (ctrl_next.mode == TCU_MODE_SPEVT);
      // go pulse on the first cycle of a trigger, gated by adc enable
      adc_go_reg  <= match_next && !match_reg &&
                     (ctrl_next.mode == TCU_MODE_SPEVT) && ctrl_next.adc_en;
      oe_reg      <= pin_mode;
      status_reg  <= status_next;
      irq_reg     <= |(status_next & mask_reg);
    end
  end

  // apb answer: data captured in setup, ready in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph && !mapped;
      prdata_reg  <= (setup_ph && !pwrite) ? rd_mux : '0;
    end
  end

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign compare_pin_o  = latch_reg;
  assign compare_pin_oe = oe_reg;
  assign special_event  = sev_reg;
  assign adc_go         = adc_go_reg;
  assign irq            = irq_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_trigger;
    special_event && tick;
  endsequence

  // first cycle of a match while the unit is in trigger mode
  sequence s_sev_match;
    match_rise && sev_mode;
  endsequence

  a_match_tracks_count: assert property (match_reg == (count == compare_reg))
    else $error("match does not follow count equality");
  a_flag_on_match: assert property (match_rise |=> status_reg[TCU_ST_MATCH_BIT])
    else $error("compare flag not set on match");
  a_flag_sticky: assert property (status_reg[TCU_ST_MATCH_BIT] && !rd_done
                                  |=> status_reg[TCU_ST_MATCH_BIT])
    else $error("compare flag dropped without a read");
  a_sev_reset_count: assert property (s_trigger |=> (count == 16'h0000) ||
                                      $past(wr_hit(req, TCU_OFS_COUNT)))
    else $error("timer not cleared by special event");
  a_sev_no_ovf: assert property (s_trigger |-> !overflow)
    else $error("overflow flagged on special event reset");
  a_adc_gate: assert property (adc_go |-> ctrl_reg.adc_en && special_event)
    else $error("adc started while disabled");
  a_zero_ctrl_low: assert property (ctrl_wr && pwdata[5:0] == 6'h00 |=> !compare_pin_o)
    else $error("latch not forced low");
  a_pin_released: assert property (ctrl_reg.mode inside {TCU_MODE_SWINT, TCU_MODE_SPEVT}
                                   |=> !compare_pin_oe)
    else $error("pin driven in non-pin mode");
  a_sev_same_cycle: assert property (sev_mode && $past(sev_mode) && count == compare_reg
                                     |-> special_event)
    else $error("trigger late on match");
  a_no_reset_wo_match: assert property (tick && !match_reg && !ctrl_wr
                                        |=> count != 16'h0000 || $past(count) == 16'hffff ||
                                            $past(wr_hit(req, TCU_OFS_COUNT)))
    else $error("timer reset without live match");

  // trigger rises with the match and is logged in the status one cycle later
  a_sev_logged: assert property (s_sev_match |->
                                 special_event ##1 status_reg[TCU_ST_SEV_BIT])
    else $error("trigger not raised or not logged on match");
  // set mode drives the latch high after a new match
  a_latch_set: assert property (match_rise && (ctrl_reg.mode == TCU_MODE_SET) && !ctrl_wr
                                |=> compare_pin_o)
    else $error("latch not set on match");
  // the pin modes take the pin one cycle after the mode is in place
  a_oe_pin_modes: assert property (pin_mode |=> compare_pin_oe)
    else $error("pin not driven in pin mode");
  // a conversion is started once per trigger, never held over two cycles
  a_adc_single: assert property (adc_go |=> !adc_go)
    else $error("adc start longer than one cycle");

endmodule : tcu_compare

// ---- tcu_pkg.sv ----
/*
  tcu_pkg: constants and types shared by the timer compare unit files.
  assumes a 32-bit apb register bus and a single 50 mhz clock.
*/
package tcu_pkg;

  // register byte offsets
  localparam logic [7:0] TCU_OFS_CTRL     = 8'h00;  // compare_control
  localparam logic [7:0] TCU_OFS_COMPARE  = 8'h04;  // compare_value
  localparam logic [7:0] TCU_OFS_COUNT    = 8'h08;  // timer_one_count
  localparam logic [7:0] TCU_OFS_STATUS   = 8'h0c;  // peripheral_flag_reg, read clears
  localparam logic [7:0] TCU_OFS_MASK     = 8'h10;  // interrupt mask
  localparam logic [7:0] TCU_OFS_PRESCALE = 8'h14;  // timer tick divider
  localparam logic [7:0] TCU_OFS_PINSTATE = 8'h18;  // read-only pin and trigger state

  // control field positions
  localparam int TCU_CTRL_MODE_LSB = 0;   // compare_mode_select, 4 bits
  localparam int TCU_CTRL_RUN_BIT  = 4;   // timer runs
  localparam int TCU_CTRL_ADC_BIT  = 5;   // adc enabled

  // status / mask bit positions
  localparam int TCU_ST_MATCH_BIT = 0;    // compare interrupt flag
  localparam int TCU_ST_OVF_BIT   = 1;    // timer_overflow_flag
  localparam int TCU_ST_SEV_BIT   = 2;    // special event issued
  localparam int TCU_ST_WIDTH     = 3;

  // reset values
  localparam logic [15:0] TCU_RST_COMPARE  = 16'hffff;
  localparam logic [7:0]  TCU_RST_PRESCALE = 8'h00;

  // compare_mode_select encodings
  typedef enum logic [3:0] {
    TCU_MODE_OFF    = 4'b0000,  // compare off, latch held; a control write of zero clears it
    TCU_MODE_TOGGLE = 4'b0010,  // toggle output on match
    TCU_MODE_SET    = 4'b1000,  // set output on match
    TCU_MODE_CLEAR  = 4'b1001,  // clear output on match
    TCU_MODE_SWINT  = 4'b1010,  // interrupt only
    TCU_MODE_SPEVT  = 4'b1011   // special event trigger
  } tcu_mode_t;

  // compare_control contents
  typedef struct packed {
    logic       adc_en;   // adc enabled
    logic       run;      // timer counting
    logic [3:0] mode;     // compare_mode_select
  } tcu_ctrl_t;

  // apb request carrier
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } tcu_apb_req_t;

endpackage : tcu_pkg

// ---- tcu_timer.sv ----
/*
  tcu_timer: 16-bit timer count with a prescaled tick, a load port and a
  synchronous clear used by the special event trigger.
  assumes one clock; the clear is honoured only on a tick edge.
*/
`timescale 1ns/1ps
module tcu_timer import tcu_pkg::*; #(
  parameter int CW = 16,                    // count width
  parameter int PW = 8                      // prescaler width
) (
  input  wire logic          pclk,          // system clock
  input  wire logic          presetn,       // async reset, low active
  input  wire logic          run,           // count enable
  input  wire logic [PW-1:0] prescale,      // tick every prescale+1 clocks
  input  wire logic          load,          // software write of count
  input  wire logic [CW-1:0] load_value,    // value written
  input  wire logic          clear_req,     // reset count on the next tick
  output logic      [CW-1:0] count,         // timer_one_count
  output logic      [CW-1:0] count_next,    // value after this edge
  output logic               tick,          // timer clock edge this cycle
  output logic               overflow       // wrap pulse
);

  logic [PW-1:0] pre_reg;                   // prescaler count
  logic [PW-1:0] pre_next;                  // its next value
  logic [CW-1:0] count_reg;                 // timer value
  logic          clear_now;                 // clear taken at this tick

  assign tick       = run && (pre_reg == prescale);
  assign pre_next   = (!run || tick) ? '0 : pre_reg + 1'b1;
  assign clear_now  = tick && clear_req;
  // clear wins over increment and never counts as overflow
  assign overflow   = tick && !clear_now && !load && (count_reg == {CW{1'b1}});
  assign count_next = load ? load_value :
                      clear_now ? '0 :
                      tick ? count_reg + 1'b1 : count_reg;
  assign count      = count_reg;

  // prescaler and count registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg   <= '0;
      count_reg <= '0;
    end else begin
      pre_reg   <= pre_next;
      count_reg <= count_next;
    end
  end

endmodule : tcu_timer

// ---- tcu_adc_model.sv ----
/*
  tcu_adc_model: stand-in for the adc start logic beside the compare unit.
  assumes the trigger is a level and the go/done set is a one-cycle pulse.
*/
`timescale 1ns/1ps
module tcu_adc_model (
  input  wire logic pclk,           // unit clock
  input  wire logic presetn,        // async reset, low active
  input  wire logic special_event,  // trigger level from the unit
  input  wire logic adc_go,         // conversion start pulse
  output int        conv_starts,    // conversions started so far
  output int        trig_seen       // trigger rises seen so far
);
  logic sev_q;  // trigger level one cycle ago

  // count trigger rises and start pulses; a long trigger is one event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_starts <= 0;
      trig_seen   <= 0;
      sev_q       <= 1'b0;
    end else begin
      sev_q <= special_event;
      if (special_event && !sev_q) begin  // one event per match
        trig_seen <= trig_seen + 1;
      end
      if (adc_go) begin  // go/done set starts a conversion
        conv_starts <= conv_starts + 1;
      end
    end
  end
endmodule : tcu_adc_model

// ---- test_timer_compare_unit.sv ----
/*
  test_timer_compare_unit: self-checking bench for tcu_compare.
  assumes zero-wait apb and the internal timer as the only timer clock.
*/
`timescale 1ns/1ps
module test_timer_compare_unit;
  import tcu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;  // bus control
  logic [7:0]  paddr;                                 // byte address
  logic [31:0] pwdata, prdata;                        // bus data
  logic        pready, pslverr, pin_o, pin_oe, sev, adc_go, irq;
  int          mismatches, checks_done, cycles;       // bookkeeping
  int          conv_starts, trig_seen;                // partner counts

  tcu_compare DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_pin_o(pin_o), .compare_pin_oe(pin_oe),
    .special_event(sev), .adc_go(adc_go), .irq(irq));
  tcu_adc_model adc (.pclk(pclk), .presetn(presetn), .special_event(sev),
    .adc_go(adc_go), .conv_starts(conv_starts), .trig_seen(trig_seen));

  // 50 mhz clock
  always #10 pclk = ~pclk;

  // hang guard, far above the under one thousand cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk

  // one apb transfer; entered just after a rising edge, leaves one idle cycle.
  // answer taken at the rising edge where pready is sampled high; only the
  // hang guard ends a wait that never sees it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask : rd

  // wait for the trigger to rise, sampled mid-cycle
  task automatic wait_rise();
    int n;
    n = 0;
    while (sev !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    chk("trigger rise", 32'h1, {31'h0, sev});
  endtask : wait_rise

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rd(TCU_OFS_CTRL, 32'h0, "ctrl reset");
    rd(TCU_OFS_COMPARE, {16'h0, TCU_RST_COMPARE}, "compare reset");
    rd(TCU_OFS_COUNT, 32'h0, "count reset");
    rd(TCU_OFS_STATUS, 32'h0, "status reset");
    rd(TCU_OFS_MASK, 32'h0, "mask reset");
    rd(TCU_OFS_PRESCALE, {24'h0, TCU_RST_PRESCALE}, "prescale reset");
    rd(TCU_OFS_PINSTATE, 32'h0, "pinstate reset");
    apb(1'b0, 8'h1c, 32'h0, r, e);  // unmapped place
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
  endtask : t_reset

  // special event: period, adc start, flags
  task automatic t_special();
    int n, a, b;
    wr(TCU_OFS_PRESCALE, 32'h0);
    wr(TCU_OFS_COMPARE, 32'h5);
    wr(TCU_OFS_COUNT, 32'h0);
    wr(TCU_OFS_CTRL, 32'h3b);  // synchronous timer run, adc on
    wait_rise();
    chk("adc go at match", 32'h1, {31'h0, adc_go});
    chk("oe in trigger mode", 32'h0, {31'h0, pin_oe});
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (sev !== 1'b1 && n < 50);
    chk("trigger period", 32'd6, n);
    @(posedge pclk);
    rd(TCU_OFS_STATUS, 32'h5, "status after trigger");
    chk("starts per trigger", trig_seen, conv_starts);
    wr(TCU_OFS_CTRL, 32'h1b);
    a = conv_starts;
    b = trig_seen;
    repeat (30) @(posedge pclk);
    chk("no start with adc off", a, conv_starts);
    chk("triggers still run", 32'h1, {31'h0, trig_seen > b});
  endtask : t_special

  // moving the compare value away before the tick cancels the clear
  task automatic t_cancel();
    logic [31:0] r;
    logic        e;
    wr(TCU_OFS_CTRL, 32'h0);
    wr(TCU_OFS_PRESCALE, 32'h9);
    wr(TCU_OFS_COMPARE, 32'h5);
    wr(TCU_OFS_COUNT, 32'h0);
    wr(TCU_OFS_CTRL, 32'h1b);
    wait_rise();
    @(posedge pclk);
    wr(TCU_OFS_COMPARE, 32'd100);
    repeat (25) @(posedge pclk);
    apb(1'b0, TCU_OFS_COUNT, 32'h0, r, e);
    chk("count not cleared", 32'h1, {31'h0, r >= 6 && r < 100});
    wr(TCU_OFS_CTRL, 32'h0);
    rd(TCU_OFS_STATUS, 32'h5, "status after cancel");
    wr(TCU_OFS_PRESCALE, 32'h0);
  endtask : t_cancel

  // one match from count 0 to compare 20 in the given mode
  task automatic do_match(input tcu_mode_t m, input logic p, input logic oe);
    wr(TCU_OFS_CTRL, {28'h0, m});
    wr(TCU_OFS_COUNT, 32'h0);
    wr(TCU_OFS_CTRL, {28'h1, m});
    repeat (40) @(posedge pclk);
    chk("pin level", {31'h0, p}, {31'h0, pin_o});
    chk("pin drive", {31'h0, oe}, {31'h0, pin_oe});  // pin used only when driven
    wr(TCU_OFS_CTRL, {28'h0, m});
    rd(TCU_OFS_STATUS, 32'h1, "match flag held");
    rd(TCU_OFS_STATUS, 32'h0, "match flag cleared");
  endtask : do_match

  task automatic t_modes();
    wr(TCU_OFS_COMPARE, 32'd20);
    do_match(TCU_MODE_SET, 1'b1, 1'b1);
    do_match(TCU_MODE_CLEAR, 1'b0, 1'b1);
    do_match(TCU_MODE_TOGGLE, 1'b1, 1'b1);
    do_match(TCU_MODE_TOGGLE, 1'b0, 1'b1);
    do_match(TCU_MODE_SWINT, 1'b0, 1'b0);
    do_match(TCU_MODE_OFF, 1'b0, 1'b0);
    do_match(TCU_MODE_SET, 1'b1, 1'b1);
    wr(TCU_OFS_CTRL, 32'h0);
    @(posedge pclk);
    chk("latch after clear", 32'h0, {30'h0, pin_o, pin_oe});
  endtask : t_modes

  // irq: raised, cleared by status read, masked, overflow source
  task automatic t_irq();
    wr(TCU_OFS_MASK, 32'h1);
    wr(TCU_OFS_CTRL, {28'h0, TCU_MODE_SWINT});
    wr(TCU_OFS_COUNT, 32'h0);
    wr(TCU_OFS_CTRL, 32'h1a);
    repeat (40) @(posedge pclk);
    chk("irq on match", 32'h1, {31'h0, irq});
    rd(TCU_OFS_STATUS, 32'h1, "irq status");
    chk("irq after read", 32'h0, {31'h0, irq});
    wr(TCU_OFS_MASK, 32'h0);
    wr(TCU_OFS_COUNT, 32'h0);
    repeat (40) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(TCU_OFS_STATUS, 32'h1, "masked status");
    wr(TCU_OFS_MASK, 32'h2);
    wr(TCU_OFS_COMPARE, 32'h8000);
    wr(TCU_OFS_CTRL, 32'h10);
    wr(TCU_OFS_COUNT, 32'hfff0);
    repeat (30) @(posedge pclk);
    chk("irq on overflow", 32'h1, {31'h0, irq});
    rd(TCU_OFS_STATUS, 32'h2, "overflow status");
    // trigger at the top of the count: the clear must not flag an overflow
    wr(TCU_OFS_COMPARE, 32'hffff);
    wr(TCU_OFS_CTRL, 32'h0b);
    wr(TCU_OFS_COUNT, 32'hfff0);
    wr(TCU_OFS_CTRL, 32'h1b);
    repeat (30) @(posedge pclk);
    rd(TCU_OFS_STATUS, 32'h5, "trigger at top");
    chk("no irq from trigger", 32'h0, {31'h0, irq});
    wr(TCU_OFS_CTRL, 32'h0);
  endtask : t_irq

  // main sequence
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("outputs after reset", 32'h0, {27'h0, pin_o, pin_oe, sev, adc_go, irq});
    t_reset();
    t_special();
    t_cancel();
    t_modes();
    t_irq();
    wrap_up();
  end
endmodule : test_timer_compare_unit
